// ==== hw/mode_sel_pkg.sv ====
// Package: constants and types shared by the operating mode selector
package mode_sel_pkg;

  // ----------------------------------------------------------------
  // Console characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CHAR_UPDATE_REQ = 8'h06;
  localparam logic [7:0] CHAR_YES = 8'h4a;
  localparam logic [7:0] CHAR_NO = 8'h4e;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int MAX_BAUD = 625000;
  // Shortest legal bit period in cycles, rounded up
  localparam int MIN_BIT_CYCLES = (CLK_HZ + MAX_BAUD - 1) / MAX_BAUD;
  localparam logic [15:0] BAUD_DIV_RESET = 16'h0010;
  localparam logic [15:0] BAUD_DIV_MIN = 16'(MIN_BIT_CYCLES);
  // Restart count loaded on entry; the restart pulse stands one cycle longer than this
  localparam logic [3:0] RESTART_CYCLES = 4'h8;

  // ----------------------------------------------------------------
  // Network
  // ----------------------------------------------------------------
  localparam logic [31:0] UPDATE_IP = 32'h0a0a0a0a;

  // ----------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_BOOT = 7'h01,
    ST_SELFTEST = 7'h02,
    ST_CFG_IDLE = 7'h04,
    ST_CFG_CONFIRM = 7'h08,
    ST_RESTART = 7'h10,
    ST_UPDATE = 7'h20,
    ST_EXCHANGE = 7'h40
  } state_e;

  typedef struct packed {
    logic exchange;
    logic cfg;
    logic update;
    logic debug;
  } mode_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } char_s;

endpackage : mode_sel_pkg

// ==== hw/operating_mode_selector.sv ====
// Operating mode selector: picks exchange, debug, configuration or firmware-update mode
`timescale 1ns/1ps
module operating_mode_selector
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Strap pins
  input wire logic boot_select_n,
  input wire logic config_select_n,
  input wire logic debug_select_n,
  // Self-test handshake
  input wire logic selfTestDone,
  input wire logic selfTestPass,
  // Console characters received
  input wire mode_sel_pkg::char_s consoleRx,
  // Script-set bit rate
  input wire logic baudWrite,
  input wire logic [15:0] baudDivIn,
  // Mode outputs
  output mode_sel_pkg::mode_s mode,
  output logic selfTestStart,
  output logic cfgReady,
  output logic confirmQuery,
  output logic restartReq,
  output logic runScript,
  output logic [31:0] netAddr,
  output logic fixedAddrUse,
  output logic [15:0] baudDiv,
  output logic selfTestFail
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic bootSelSync;
  logic cfgSelSync;
  logic dbgSelSync;

  sync_2ff u_sync_boot (.sys_clk(sys_clk), .nrst(nrst), .din(boot_select_n), .dout(bootSelSync));
  sync_2ff u_sync_cfg (.sys_clk(sys_clk), .nrst(nrst), .din(config_select_n), .dout(cfgSelSync));
  sync_2ff u_sync_dbg (.sys_clk(sys_clk), .nrst(nrst), .din(debug_select_n), .dout(dbgSelSync));

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  mode_sel_pkg::state_e state;
  mode_sel_pkg::state_e next_state;
  logic [1:0] bootWait;
  logic [1:0] next_bootWait;
  logic [3:0] restartCnt;
  logic [3:0] next_restartCnt;
  logic updateLatched;
  logic next_updateLatched;
  logic debugLatched;
  logic next_debugLatched;
  logic next_selfTestFail;

  always_comb
  begin
    next_state = state;
    next_bootWait = bootWait;
    next_restartCnt = restartCnt;
    next_updateLatched = updateLatched;
    next_debugLatched = debugLatched;
    next_selfTestFail = selfTestFail;
    case (state)
      mode_sel_pkg::ST_BOOT:
      begin
        // Wait for synchronisers to carry the straps through
        if (bootWait != 2'h3)
        begin
          next_bootWait = bootWait + 2'h1;
        end
        else if (!bootSelSync || updateLatched)
        begin
          next_state = mode_sel_pkg::ST_UPDATE;
        end
        else if (!cfgSelSync)
        begin
          next_state = mode_sel_pkg::ST_SELFTEST;
          next_selfTestFail = 1'b0;
        end
        else
        begin
          next_debugLatched = !dbgSelSync;
          next_state = mode_sel_pkg::ST_EXCHANGE;
        end
      end
      mode_sel_pkg::ST_SELFTEST:
      begin
        if (selfTestDone)
        begin
          if (selfTestPass)
          begin
            next_state = mode_sel_pkg::ST_CFG_IDLE;
          end
          else
          begin
            // A failed test leaves the device parked here
            next_selfTestFail = 1'b1;
          end
        end
      end
      mode_sel_pkg::ST_CFG_IDLE:
      begin
        if (consoleRx.valid && consoleRx.data == mode_sel_pkg::CHAR_UPDATE_REQ)
        begin
          next_state = mode_sel_pkg::ST_CFG_CONFIRM;
        end
      end
      mode_sel_pkg::ST_CFG_CONFIRM:
      begin
        if (consoleRx.valid && consoleRx.data == mode_sel_pkg::CHAR_YES)
        begin
          next_state = mode_sel_pkg::ST_RESTART;
          next_updateLatched = 1'b1;
          next_restartCnt = mode_sel_pkg::RESTART_CYCLES;
        end
        else if (consoleRx.valid && consoleRx.data == mode_sel_pkg::CHAR_NO)
        begin
          next_state = mode_sel_pkg::ST_CFG_IDLE;
        end
      end
      mode_sel_pkg::ST_RESTART:
      begin
        if (restartCnt != 4'h0)
        begin
          next_restartCnt = restartCnt - 4'h1;
        end
        else
        begin
          next_bootWait = 2'h0;
          next_state = mode_sel_pkg::ST_BOOT;
        end
      end
      mode_sel_pkg::ST_UPDATE:
      begin
        // No exit short of reset: an update cannot be undone
        next_state = mode_sel_pkg::ST_UPDATE;
      end
      mode_sel_pkg::ST_EXCHANGE:
      begin
        next_state = mode_sel_pkg::ST_EXCHANGE;
      end
      default:
      begin
        next_state = mode_sel_pkg::ST_BOOT;
      end
    endcase
  end

  // Update request survives the internal restart, not an external reset
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      state <= mode_sel_pkg::ST_BOOT;
      bootWait <= 2'h0;
      restartCnt <= 4'h0;
      updateLatched <= 1'b0;
      debugLatched <= 1'b0;
      selfTestFail <= 1'b0;
    end
    else
    begin
      state <= next_state;
      bootWait <= next_bootWait;
      restartCnt <= next_restartCnt;
      updateLatched <= next_updateLatched;
      debugLatched <= next_debugLatched;
      selfTestFail <= next_selfTestFail;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  mode_sel_pkg::mode_s next_mode;
  logic next_selfTestStart;
  logic next_cfgReady;
  logic next_confirmQuery;
  logic next_restartReq;
  logic next_runScript;
  logic [31:0] next_netAddr;
  logic next_fixedAddrUse;
  logic [15:0] next_baudDiv;

  always_comb
  begin
    next_mode.update = (next_state == mode_sel_pkg::ST_UPDATE);
    next_mode.cfg = (next_state == mode_sel_pkg::ST_SELFTEST) || (next_state == mode_sel_pkg::ST_CFG_IDLE)
      || (next_state == mode_sel_pkg::ST_CFG_CONFIRM);
    next_mode.debug = (next_state == mode_sel_pkg::ST_EXCHANGE) && next_debugLatched;
    next_mode.exchange = (next_state == mode_sel_pkg::ST_EXCHANGE) && !next_debugLatched;
    next_selfTestStart = (next_state == mode_sel_pkg::ST_SELFTEST) && (state != mode_sel_pkg::ST_SELFTEST);
    next_cfgReady = (next_state == mode_sel_pkg::ST_CFG_IDLE);
    next_confirmQuery = (next_state == mode_sel_pkg::ST_CFG_CONFIRM) && (state != mode_sel_pkg::ST_CFG_CONFIRM);
    next_restartReq = (next_state == mode_sel_pkg::ST_RESTART);
    next_runScript = next_mode.exchange;
    next_fixedAddrUse = next_mode.update;
    next_netAddr = next_mode.update ? mode_sel_pkg::UPDATE_IP : 32'h00000000;
    next_baudDiv = baudDiv;
    if (baudWrite && next_mode.exchange)
    begin
      // Requests faster than the ceiling are clamped
      next_baudDiv = (baudDivIn < mode_sel_pkg::BAUD_DIV_MIN) ? mode_sel_pkg::BAUD_DIV_MIN : baudDivIn;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      mode <= '0;
      selfTestStart <= 1'b0;
      cfgReady <= 1'b0;
      confirmQuery <= 1'b0;
      restartReq <= 1'b0;
      runScript <= 1'b0;
      netAddr <= 32'h00000000;
      fixedAddrUse <= 1'b0;
      baudDiv <= mode_sel_pkg::BAUD_DIV_RESET;
    end
    else
    begin
      mode <= next_mode;
      selfTestStart <= next_selfTestStart;
      cfgReady <= next_cfgReady;
      confirmQuery <= next_confirmQuery;
      restartReq <= next_restartReq;
      runScript <= next_runScript;
      netAddr <= next_netAddr;
      fixedAddrUse <= next_fixedAddrUse;
      baudDiv <= next_baudDiv;
    end
  end

endmodule : operating_mode_selector

// ==== hw/sync_2ff.sv ====
// Two-flop synchroniser for a pin level
`timescale 1ns/1ps
module sync_2ff
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Level
  input wire logic din,
  output logic dout
);

  logic meta;
  logic next_meta;
  logic next_dout;

  always_comb
  begin
    next_meta = din;
    next_dout = meta;
  end

  // Resets to high: pins here are active low
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      meta <= 1'b1;
      dout <= 1'b1;
    end
    else
    begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end

endmodule : sync_2ff

// ==== verification/host_console.sv ====
// Partner: host console on the configuration link
`timescale 1ns/1ps
module host_console
(
  // Clock
  input wire logic sys_clk,
  // Query from the device
  input wire logic confirmQuery,
  // Characters to the device
  output mode_sel_pkg::char_s consoleRx
);
  initial consoleRx = '0;
  // One character for one cycle; data is scrambled once released
  task automatic send(input logic [7:0] ch);
    @(posedge sys_clk);
    consoleRx <= {1'b1, ch};
    @(posedge sys_clk);
    consoleRx <= {1'b0, ~ch};
  endtask : send
  // Request an update, wait for the query, answer after gap cycles
  task automatic request(input logic [7:0] ans, input int gap, output bit seen);
    seen = 0;
    send(mode_sel_pkg::CHAR_UPDATE_REQ);
    repeat (10)
    begin
      @(posedge sys_clk);
      if (confirmQuery)
      begin
        seen = 1;
        break;
      end
    end
    repeat (gap) @(posedge sys_clk);
    if (seen)
      send(ans);
  endtask : request
endmodule : host_console

// ==== verification/mode_sel_chk.sv ====
// Checker: port-level properties of the operating mode selector
`timescale 1ns/1ps
module mode_sel_chk
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Inputs
  input wire mode_sel_pkg::char_s consoleRx,
  input wire logic baudWrite,
  input wire logic [15:0] baudDivIn,
  // Outputs
  input wire mode_sel_pkg::mode_s mode,
  input wire logic selfTestStart,
  input wire logic cfgReady,
  input wire logic confirmQuery,
  input wire logic restartReq,
  input wire logic runScript,
  input wire logic [31:0] netAddr,
  input wire logic fixedAddrUse,
  input wire logic [15:0] baudDiv,
  input wire logic selfTestFail
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic asked;
  logic next_asked;
  logic ansYes;
  logic ansNo;
  logic [15:0] wantDiv;
  assign ansYes = consoleRx.valid && consoleRx.data == mode_sel_pkg::CHAR_YES;
  assign ansNo = consoleRx.valid && consoleRx.data == mode_sel_pkg::CHAR_NO;
  // Too small a divider is floored, not ignored
  assign wantDiv = baudDivIn < mode_sel_pkg::BAUD_DIV_MIN ? mode_sel_pkg::BAUD_DIV_MIN : baudDivIn;
  // Open query: opened by the query pulse, closed by either answer; the answer may come with the pulse itself
  always_comb
  begin
    next_asked = asked;
    if (ansYes || ansNo)
      next_asked = 1'b0;
    else if (confirmQuery)
      next_asked = 1'b1;
  end
  always_ff @(posedge sys_clk)
    asked <= nrst && next_asked;
  AST_QUERY: assert property (consoleRx.valid && consoleRx.data == mode_sel_pkg::CHAR_UPDATE_REQ
    && cfgReady |=> confirmQuery && !cfgReady) else $error("update request not answered by query");
  AST_YES: assert property ((asked || confirmQuery) && ansYes |=> restartReq && !mode.cfg)
    else $error("positive answer did not restart");
  AST_RESTART: assert property ($rose(restartReq) |-> restartReq[*8] ##1 restartReq ##[1:8] mode.update)
    else $error("restart did not end in update mode");
  AST_NO: assert property ((asked || confirmQuery) && ansNo |=> cfgReady && mode.cfg)
    else $error("negative answer did not return to idle");
  AST_SELFTEST: assert property ($rose(mode.cfg) |-> selfTestStart && !cfgReady)
    else $error("configuration entered without self-test");
  AST_IDLE: assert property (cfgReady |-> mode.cfg && !selfTestFail)
    else $error("idle without passed self-test");
  AST_ADDR: assert property (mode.update |-> netAddr == mode_sel_pkg::UPDATE_IP && fixedAddrUse)
    else $error("update mode without fixed address");
  AST_HOLD: assert property (mode.update |=> mode.update && !restartReq)
    else $error("update mode left");
  AST_SCRIPT: assert property (runScript == mode.exchange)
    else $error("script run does not follow exchange mode");
  AST_BAUD: assert property (baudWrite && mode.exchange |=> baudDiv == $past(wantDiv))
    else $error("bit rate divider not taken");
endmodule : mode_sel_chk

bind operating_mode_selector mode_sel_chk chk (.sys_clk, .nrst, .consoleRx, .baudWrite, .baudDivIn, .mode,
  .selfTestStart, .cfgReady, .confirmQuery, .restartReq, .runScript, .netAddr, .fixedAddrUse, .baudDiv, .selfTestFail);

// ==== verification/testbench.sv ====
// Testbench: self-checking run of the operating mode selector
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 0;
  logic nrst = 0;
  logic boot_select_n = 1;
  logic config_select_n = 1;
  logic debug_select_n = 1;
  logic selfTestDone = 0;
  logic selfTestPass = 0;
  logic baudWrite = 0;
  logic [15:0] baudDivIn = '0;
  mode_sel_pkg::char_s consoleRx;
  mode_sel_pkg::mode_s mode;
  logic selfTestStart, cfgReady, confirmQuery, restartReq, runScript, fixedAddrUse, selfTestFail;
  logic [31:0] netAddr;
  logic [15:0] baudDiv;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  bit seen;
  logic [2:0] straps [4] = '{3'b000, 3'b101, 3'b110, 3'b111};
  logic [3:0] modes [4] = '{4'b0010, 4'b0100, 4'b0001, 4'b1000};
  always #50 sys_clk = ~sys_clk;
  operating_mode_selector dut (.sys_clk, .nrst, .boot_select_n, .config_select_n, .debug_select_n,
    .selfTestDone, .selfTestPass, .consoleRx, .baudWrite, .baudDivIn, .mode, .selfTestStart, .cfgReady,
    .confirmQuery, .restartReq, .runScript, .netAddr, .fixedAddrUse, .baudDiv, .selfTestFail);
  host_console host (.sys_clk, .confirmQuery, .consoleRx);
  // A hang counts as a mismatch
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic boot(input logic [2:0] s);
    @(posedge sys_clk);
    nrst <= 0;
    {boot_select_n, config_select_n, debug_select_n} <= s;
    repeat (20) @(posedge sys_clk);
    nrst <= 1;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : boot
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle
  task automatic test_done(input logic pass);
    @(posedge sys_clk);
    selfTestDone <= 1;
    selfTestPass <= pass;
    @(posedge sys_clk);
    selfTestDone <= 0;
    settle(3);
  endtask : test_done
  task automatic write_baud(input logic [15:0] d);
    @(posedge sys_clk);
    baudWrite <= 1;
    baudDivIn <= d;
    @(posedge sys_clk);
    baudWrite <= 0;
    settle(2);
  endtask : write_baud
  task automatic t_straps();
    for (int i = 0; i < 4; i++)
    begin
      boot(straps[i]);
      chk("mode", modes[i], mode);
      chk("runScript", modes[i][3], runScript);
      chk("netAddr", modes[i][1] ? mode_sel_pkg::UPDATE_IP : 0, netAddr);
    end
    // Enter update mode by strap, then let go of the strap: the mode must stay
    boot(3'b011);
    @(posedge sys_clk);
    boot_select_n <= 1;
    settle(5);
    chk("mode", 4'b0010, mode);
    $display("test straps done");
  endtask : t_straps
  task automatic t_config();
    boot(3'b101);
    chk("cfgReady", 0, cfgReady);
    test_done(1);
    chk("cfgReady", 1, cfgReady);
    host.send(8'h41);
    host.send(mode_sel_pkg::CHAR_YES);
    settle(3);
    chk("cfgReady", 1, cfgReady);
    chk("restartReq", 0, restartReq);
    host.request(mode_sel_pkg::CHAR_NO, 3, seen);
    chk("query", 1, seen);
    settle(3);
    chk("cfgReady", 1, cfgReady);
    chk("mode", 4'b0100, mode);
    host.request(mode_sel_pkg::CHAR_YES, 0, seen);
    chk("query", 1, seen);
    settle(25);
    chk("mode", 4'b0010, mode);
    chk("fixedAddrUse", 1, fixedAddrUse);
    host.send(mode_sel_pkg::CHAR_UPDATE_REQ);
    settle(12);
    chk("mode", 4'b0010, mode);
    $display("test config done");
  endtask : t_config
  task automatic t_fail();
    boot(3'b101);
    test_done(0);
    chk("selfTestFail", 1, selfTestFail);
    chk("cfgReady", 0, cfgReady);
    host.request(mode_sel_pkg::CHAR_YES, 0, seen);
    chk("query", 0, seen);
    write_baud(16'h0040);
    chk("baudDiv", mode_sel_pkg::BAUD_DIV_RESET, baudDiv);
    $display("test fail done");
  endtask : t_fail
  task automatic t_baud();
    boot(3'b111);
    write_baud(16'h0020);
    chk("baudDiv", 16'h0020, baudDiv);
    write_baud(16'h0005);
    chk("baudDiv", mode_sel_pkg::BAUD_DIV_MIN, baudDiv);
    $display("test baud done");
  endtask : t_baud
  initial
  begin
    t_straps();
    t_config();
    t_fail();
    t_baud();
    give_verdict();
  end
endmodule : testbench
